// ===== rtl/intc_params.svh
// Purpose: Constants for the interrupt priority resolver and vector generator.
// Assumes: Vector addresses are twice the vector number, 16 bits wide.
// Notes: Vector numbers double as priorities; lower number wins.
// How it works
// - Smallest pending vector number wins.
// - Intra-module priority is fixed in hardware.
// - Vector address equals twice vector number.
// - A/D done uses vector 14.
// - Capture A-D use vectors 15-18.
// - Compare A/B 19-20, overflow 21.
// - Paired timer uses vectors 28-31.
// - Serial receive error 36, full 37.
// - Serial transmit empty 38, end 39.
// - Non-maskable interrupt uses vector 4, top priority.
// - Pin requests 0-2 use vectors 5-7.
// - Losing requests stay pending, never dropped.
// - Mask bit set accepts only non-maskable.
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH
`define VEC_NMI        6'h04
`define VEC_IRQ0       6'h05
`define VEC_IRQ1       6'h06
`define VEC_IRQ2       6'h07
`define VEC_WDT        6'h0D
`define VEC_ADC        6'h0E
`define VEC_FRT_ICA    6'h0F
`define VEC_FRT_ICB    6'h10
`define VEC_FRT_ICC    6'h11
`define VEC_FRT_ICD    6'h12
`define VEC_FRT_OCA    6'h13
`define VEC_FRT_OCB    6'h14
`define VEC_FRT_OVF    6'h15
`define VEC_TMR0_A     6'h16
`define VEC_TMR0_B     6'h17
`define VEC_TMR0_OVF   6'h18
`define VEC_TMR1_A     6'h19
`define VEC_TMR1_B     6'h1A
`define VEC_TMR1_OVF   6'h1B
`define VEC_PAIR_A     6'h1C
`define VEC_PAIR_B     6'h1D
`define VEC_PAIR_OVF   6'h1E
`define VEC_PAIR_CAP   6'h1F
`define VEC_SCI_ERR    6'h24
`define VEC_SCI_RXF    6'h25
`define VEC_SCI_TXE    6'h26
`define VEC_SCI_TEND   6'h27
`define VEC_TW0_BYTE   6'h2C
`define VEC_TW_FMT     6'h2D
`define VEC_TW1_BYTE   6'h2E
`define VEC_USB_A      6'h32
`define VEC_USB_B      6'h33
`define VEC_USB_C      6'h34
`define VEC_USB_D      6'h35
`define VEC_NONE       6'h00
`define VEC_ADDR_SHIFT 1
`define NUM_SRC        34
`endif

// ===== rtl/intc_pkg.sv
// Purpose: Types for the interrupt resolver.
// Assumes: Vector numbers fit in six bits.
// Notes: Constants live in the params header.
package intc_pkg;
  typedef logic [5:0]  vec_num_t;
  typedef logic [15:0] vec_addr_t;
endpackage

// ===== rtl/interrupt_vector_priority.sv
// Purpose: Fixed-priority interrupt resolver producing vector number and address.
// Assumes: Request inputs are enabled levels, synchronous to clk.
// Notes: One cycle from request to registered vector; requests are never latched.
`timescale 1ns/10ps
`include "intc_params.svh"
module interrupt_vector_priority (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                mask_bit,
  input  wire logic                nmi_req,
  input  wire logic [2:0]          pin_irq_req,
  input  wire logic                watchdog_interval_req,
  input  wire logic                adc_done_req,
  input  wire logic                frt_capture_a_req,
  input  wire logic                frt_capture_b_req,
  input  wire logic                frt_capture_c_req,
  input  wire logic                frt_capture_d_req,
  input  wire logic                frt_compare_a_req,
  input  wire logic                frt_compare_b_req,
  input  wire logic                frt_overflow_req,
  input  wire logic                tmr0_match_a_req,
  input  wire logic                tmr0_match_b_req,
  input  wire logic                tmr0_overflow_req,
  input  wire logic                tmr1_match_a_req,
  input  wire logic                tmr1_match_b_req,
  input  wire logic                tmr1_overflow_req,
  input  wire logic                pair_timer_match_a_req,
  input  wire logic                pair_timer_match_b_req,
  input  wire logic                pair_timer_overflow_req,
  input  wire logic                pair_timer_capture_req,
  input  wire logic                serial_rx_error_req,
  input  wire logic                serial_rx_full_req,
  input  wire logic                serial_tx_empty_req,
  input  wire logic                serial_tx_end_req,
  input  wire logic                twowire0_byte_done_req,
  input  wire logic                twowire_format_switch_req,
  input  wire logic                twowire1_byte_done_req,
  input  wire logic                usb_req_a,
  input  wire logic                usb_req_b,
  input  wire logic                usb_req_c,
  input  wire logic                usb_req_d,
  output logic                     irq_valid,
  output intc_pkg::vec_num_t       vec_num,
  output intc_pkg::vec_addr_t      vec_addr
);
  localparam int N = `NUM_SRC;

  ////////////////////////////////////////////////////////////////////////////
  // Source table: request and fixed vector per slot
  logic                 src_req [N];
  intc_pkg::vec_num_t   src_num [N];
  logic                 maskable_gate;

  // Mask bit blocks everything but the non-maskable source
  assign maskable_gate = ~mask_bit;

  // Gated request per slot; the mask spares only slot 0
  always_comb begin
    // Non-maskable and external pins
    src_req[0]  = nmi_req;
    src_req[1]  = pin_irq_req[0] & maskable_gate;
    src_req[2]  = pin_irq_req[1] & maskable_gate;
    src_req[3]  = pin_irq_req[2] & maskable_gate;

    // Watchdog and converter
    src_req[4]  = watchdog_interval_req & maskable_gate;
    src_req[5]  = adc_done_req & maskable_gate;

    // Free-running timer captures
    src_req[6]  = frt_capture_a_req & maskable_gate;
    src_req[7]  = frt_capture_b_req & maskable_gate;
    src_req[8]  = frt_capture_c_req & maskable_gate;
    src_req[9]  = frt_capture_d_req & maskable_gate;

    // Free-running timer compares and overflow
    src_req[10] = frt_compare_a_req & maskable_gate;
    src_req[11] = frt_compare_b_req & maskable_gate;
    src_req[12] = frt_overflow_req & maskable_gate;

    // Timer channel 0
    src_req[13] = tmr0_match_a_req & maskable_gate;
    src_req[14] = tmr0_match_b_req & maskable_gate;
    src_req[15] = tmr0_overflow_req & maskable_gate;

    // Timer channel 1
    src_req[16] = tmr1_match_a_req & maskable_gate;
    src_req[17] = tmr1_match_b_req & maskable_gate;
    src_req[18] = tmr1_overflow_req & maskable_gate;

    // Paired timer channels
    src_req[19] = pair_timer_match_a_req & maskable_gate;
    src_req[20] = pair_timer_match_b_req & maskable_gate;
    src_req[21] = pair_timer_overflow_req & maskable_gate;
    src_req[22] = pair_timer_capture_req & maskable_gate;

    // Serial receive side
    src_req[23] = serial_rx_error_req & maskable_gate;
    src_req[24] = serial_rx_full_req & maskable_gate;

    // Serial transmit side
    src_req[25] = serial_tx_empty_req & maskable_gate;
    src_req[26] = serial_tx_end_req & maskable_gate;

    // Two-wire channels
    src_req[27] = twowire0_byte_done_req & maskable_gate;
    src_req[28] = twowire_format_switch_req & maskable_gate;
    src_req[29] = twowire1_byte_done_req & maskable_gate;

    // Bus device requests
    src_req[30] = usb_req_a & maskable_gate;
    src_req[31] = usb_req_b & maskable_gate;
    src_req[32] = usb_req_c & maskable_gate;
    src_req[33] = usb_req_d & maskable_gate;
  end

  // Fixed vector per slot; ascending so chain order is priority
  always_comb begin
    // Non-maskable and external pins
    src_num[0]  = `VEC_NMI;
    src_num[1]  = `VEC_IRQ0;
    src_num[2]  = `VEC_IRQ1;
    src_num[3]  = `VEC_IRQ2;

    // Watchdog and converter
    src_num[4]  = `VEC_WDT;
    src_num[5]  = `VEC_ADC;

    // Free-running timer captures
    src_num[6]  = `VEC_FRT_ICA;
    src_num[7]  = `VEC_FRT_ICB;
    src_num[8]  = `VEC_FRT_ICC;
    src_num[9]  = `VEC_FRT_ICD;

    // Free-running timer compares and overflow
    src_num[10] = `VEC_FRT_OCA;
    src_num[11] = `VEC_FRT_OCB;
    src_num[12] = `VEC_FRT_OVF;

    // Timer channel 0
    src_num[13] = `VEC_TMR0_A;
    src_num[14] = `VEC_TMR0_B;
    src_num[15] = `VEC_TMR0_OVF;

    // Timer channel 1
    src_num[16] = `VEC_TMR1_A;
    src_num[17] = `VEC_TMR1_B;
    src_num[18] = `VEC_TMR1_OVF;

    // Paired timer channels
    src_num[19] = `VEC_PAIR_A;
    src_num[20] = `VEC_PAIR_B;
    src_num[21] = `VEC_PAIR_OVF;
    src_num[22] = `VEC_PAIR_CAP;

    // Serial receive side
    src_num[23] = `VEC_SCI_ERR;
    src_num[24] = `VEC_SCI_RXF;

    // Serial transmit side
    src_num[25] = `VEC_SCI_TXE;
    src_num[26] = `VEC_SCI_TEND;

    // Two-wire channels
    src_num[27] = `VEC_TW0_BYTE;
    src_num[28] = `VEC_TW_FMT;
    src_num[29] = `VEC_TW1_BYTE;

    // Bus device requests
    src_num[30] = `VEC_USB_A;
    src_num[31] = `VEC_USB_B;
    src_num[32] = `VEC_USB_C;
    src_num[33] = `VEC_USB_D;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linear compare chain; only table numbers can emerge
  vec_req_if stage [N] ();
  vec_req_if leaf  [N] ();

  // First stage passes slot 0 directly
  assign stage[0].req = src_req[0];
  assign stage[0].num = src_num[0];

  genvar g;
  generate
    for (g = 1; g < N; g++) begin : g_chain
      assign leaf[g].req = src_req[g];
      assign leaf[g].num = src_num[g];
      // Order fixed by wiring, no software say in it
      prio_pick u_pick (
        .a (stage[g-1]),
        .b (leaf[g]),
        .y (stage[g])
      );
    end
  endgenerate

  // Unused leaf 0 tied off
  assign leaf[0].req = 1'b0;
  assign leaf[0].num = `VEC_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers; inputs are levels so losers stay pending at source
  logic                valid_r;
  logic                valid_nxt;
  intc_pkg::vec_num_t  num_r;
  intc_pkg::vec_num_t  num_nxt;
  intc_pkg::vec_addr_t addr_r;
  intc_pkg::vec_addr_t addr_nxt;

  // Next winner and its address
  always_comb begin
    valid_nxt = stage[N-1].req;
    num_nxt   = stage[N-1].req ? stage[N-1].num : `VEC_NONE;
    addr_nxt  = {9'h000, num_nxt, 1'b0};
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
      num_r   <= `VEC_NONE;
      addr_r  <= 16'h0000;
    end else begin
      valid_r <= valid_nxt;
      num_r   <= num_nxt;
      addr_r  <= addr_nxt;
    end
  end

  assign irq_valid = valid_r;
  assign vec_num   = num_r;
  assign vec_addr  = addr_r;
endmodule // interrupt_vector_priority

// ===== rtl/prio_pick.sv
// Purpose: Picks the lower vector number of two candidates.
// Assumes: A candidate without request never wins.
// Notes: Chain element of the priority resolver.
`timescale 1ns/10ps
`include "intc_params.svh"
module prio_pick (
  vec_req_if.dst a,
  vec_req_if.dst b,
  vec_req_if.src y
);
  // Lower number wins; ties impossible
  always_comb begin
    y.req = a.req | b.req;
    if (a.req && (!b.req || (a.num < b.num))) begin
      y.num = a.num;
    end else if (b.req) begin
      y.num = b.num;
    end else begin
      y.num = `VEC_NONE;
    end
  end
endmodule // prio_pick

// ===== rtl/vec_req_if.sv
// Purpose: Carries one source's request and its vector number.
// Assumes: Request is a level held by the source until serviced.
// Notes: Used between the resolver and its priority slice.
`timescale 1ns/10ps
interface vec_req_if;
  logic              req;
  intc_pkg::vec_num_t num;
  modport src (output req, output num);
  modport dst (input req, input num);
endinterface

// ===== tb/cpu_model.sv
// Purpose: Core side that takes a vector and masks further requests.
// Assumes: Acceptance is commanded by the bench.
// Notes: Unmask stands for a return from the handler.
`timescale 1ns/10ps
module cpu_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               irq_valid,
  input  wire intc_pkg::vec_num_t vec_num,
  input  wire logic               accept,
  input  wire logic               unmask,
  output logic                    mask_bit,
  output intc_pkg::vec_num_t      taken_num
);
  // Mask raised on acceptance, as after exception entry
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_bit <= 1'b0;
      taken_num <= 6'h00;
    end else if (accept && irq_valid) begin
      mask_bit <= 1'b1;
      taken_num <= vec_num;
    end else if (unmask) begin
      mask_bit <= 1'b0;
    end
  end
endmodule // cpu_model

// ===== tb/ivp_properties.sv
// Purpose: Port assertions for the interrupt resolver.
// Assumes: One clock, synchronous active-high reset, one cycle latency.
// Notes: Bound to the resolver top module.
`timescale 1ns/10ps
module ivp_properties (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                mask_bit,
  input wire logic                nmi_req,
  input wire logic [2:0]          pin_irq_req,
  input wire logic                adc_done_req,
  input wire logic                frt_capture_a_req,
  input wire logic                usb_req_d,
  input wire logic                irq_valid,
  input wire intc_pkg::vec_num_t  vec_num,
  input wire intc_pkg::vec_addr_t vec_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Address and winner checks
  addr_double_a: assert property (vec_addr == {9'h000, vec_num, 1'b0} && (irq_valid || vec_num == 6'h00))
    else $error("vector address not twice vector number");
  nmi_top_a: assert property (nmi_req |=> irq_valid && vec_num == 6'h04)
    else $error("non-maskable request not on vector 4");
  mask_block_a: assert property (mask_bit && !nmi_req |=> !irq_valid)
    else $error("masked request accepted");
  no_reserved_a: assert property (irq_valid |-> !(vec_num inside {[8:12], [32:35], [40:43], [47:49]}))
    else $error("reserved vector produced");
  pin_zero_a: assert property (pin_irq_req[0] && !mask_bit && !nmi_req |=> vec_num == 6'h05)
    else $error("pin 0 request not on vector 5");
  adc_wins_a: assert property (adc_done_req && !mask_bit |=> irq_valid && vec_num <= 6'h0E)
    else $error("done request lost to lower priority");
  capture_held_a: assert property (frt_capture_a_req && !mask_bit |=> irq_valid && vec_num <= 6'h0F)
    else $error("pending capture request dropped");
  usb_seen_a: assert property (usb_req_d && !mask_bit |=> irq_valid && vec_num <= 6'h35)
    else $error("lowest source not served");
endmodule // ivp_properties
////////////////////////////////////////////////////////////////////////////////
bind interrupt_vector_priority ivp_properties i_ivp_properties (.clk, .rst, .mask_bit, .nmi_req, .pin_irq_req,
  .adc_done_req, .frt_capture_a_req, .usb_req_d, .irq_valid, .vec_num, .vec_addr);

// ===== tb/test_interrupt_vector_priority.sv
// Purpose: Self-checking bench for the interrupt resolver.
// Assumes: Request bit i maps to sources in ascending vector order.
// Notes: Outputs are checked on the falling edge.
`timescale 1ns/10ps
module test_interrupt_vector_priority;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [33:0]         req = '0;
  logic                accept = 1'b0;
  logic                unmask = 1'b0;
  logic                mask_bit;
  logic                irq_valid;
  intc_pkg::vec_num_t  vec_num;
  intc_pkg::vec_num_t  taken_num;
  intc_pkg::vec_addr_t vec_addr;
  int                  failures = 0;
  int                  checks = 0;
  int                  cycles = 0;
  always #20 clk = ~clk;
  interrupt_vector_priority i_interrupt_vector_priority (.clk, .rst, .mask_bit, .nmi_req(req[0]),
    .pin_irq_req(req[3:1]), .watchdog_interval_req(req[4]), .adc_done_req(req[5]), .frt_capture_a_req(req[6]),
    .frt_capture_b_req(req[7]), .frt_capture_c_req(req[8]), .frt_capture_d_req(req[9]),
    .frt_compare_a_req(req[10]), .frt_compare_b_req(req[11]), .frt_overflow_req(req[12]),
    .tmr0_match_a_req(req[13]), .tmr0_match_b_req(req[14]), .tmr0_overflow_req(req[15]),
    .tmr1_match_a_req(req[16]), .tmr1_match_b_req(req[17]), .tmr1_overflow_req(req[18]),
    .pair_timer_match_a_req(req[19]), .pair_timer_match_b_req(req[20]), .pair_timer_overflow_req(req[21]),
    .pair_timer_capture_req(req[22]), .serial_rx_error_req(req[23]), .serial_rx_full_req(req[24]),
    .serial_tx_empty_req(req[25]), .serial_tx_end_req(req[26]), .twowire0_byte_done_req(req[27]),
    .twowire_format_switch_req(req[28]), .twowire1_byte_done_req(req[29]), .usb_req_a(req[30]),
    .usb_req_b(req[31]), .usb_req_c(req[32]), .usb_req_d(req[33]), .irq_valid, .vec_num, .vec_addr);
  cpu_model i_cpu_model (.clk, .rst, .irq_valid, .vec_num, .accept, .unmask, .mask_bit, .taken_num);
  ////////////////////////////////////////////////////////////////////////////////
  // Expected vector of request bit i, skipping reserved gaps
  function automatic intc_pkg::vec_num_t vec_of(input int i);
    return (i < 4) ? 6'(i + 4) : (i < 23) ? 6'(i + 9) : (i < 27) ? 6'(i + 13) : (i < 30) ? 6'(i + 17) : 6'(i + 20);
  endfunction
  // Drive a request pattern, then compare the registered answer
  task automatic apply(input logic [33:0] v, input logic vld, input intc_pkg::vec_num_t n);
    @(posedge clk);
    req <= v;
    @(posedge clk);
    @(negedge clk);
    checks++;
    if (irq_valid !== vld || vec_num !== n || vec_addr !== {9'h000, n, 1'b0}) begin
      failures++;
      $display("ERROR t=%0t got %h %h %h exp %h %h", $time, irq_valid, vec_num, vec_addr, vld, n);
    end
  endtask
  task automatic t_each;
    for (int i = 0; i < 34; i++) begin
      apply(34'h1 << i, 1'b1, vec_of(i));
    end
  endtask
  task automatic t_prio;
    for (int i = 0; i < 34; i++) begin
      apply(~34'h0 << i, 1'b1, vec_of(i));
    end
  endtask
  // Mask by acceptance, only the non-maskable passes, then held requests return
  task automatic t_mask;
    apply(34'h0F0, 1'b1, 6'h0D);
    @(posedge clk) accept <= 1'b1;
    @(posedge clk) accept <= 1'b0;
    apply(34'h0F0, 1'b0, 6'h00);
    checks++;
    if (taken_num !== 6'h0D) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, taken_num, 6'h0D);
    end
    apply(34'h0F1, 1'b1, 6'h04);
    @(posedge clk) unmask <= 1'b1;
    @(posedge clk) unmask <= 1'b0;
    apply(34'h0F0, 1'b1, 6'h0D);
  endtask
  task automatic t_drop;
    apply(34'h060, 1'b1, 6'h0E);
    apply(34'h040, 1'b1, 6'h0F);
    apply(34'h0, 1'b0, 6'h00);
  endtask
  // Mid-run reset clears the outputs, then requests are served again
  task automatic t_reset;
    @(posedge clk);
    req <= 34'h2;
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    checks++;
    if (irq_valid !== 1'b0 || vec_num !== 6'h00 || vec_addr !== 16'h0000) begin
      failures++;
      $display("ERROR t=%0t got %h %h %h exp %h %h %h", $time, irq_valid, vec_num, vec_addr, 1'b0, 6'h00, 16'h0000);
    end
    @(posedge clk);
    rst <= 1'b0;
    apply(34'h2, 1'b1, 6'h05);
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_each;
    t_prio;
    t_mask;
    t_drop;
    t_reset;
    complete_run;
  end
endmodule // test_interrupt_vector_priority
